// File: mat_alert_thresholds.sv
// top: threshold registers over axi4-lite, hysteretic current and aux alerts and a plain comparator cell alert
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module mat_alert_thresholds
  import mat_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [DATA_W-1:0]         s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [DATA_W-1:0]              s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire mat_pkg::mat_sample_t      current_sample,
  input  wire mat_pkg::mat_aux_sample_t  aux_sample,
  input  wire mat_pkg::mat_cmp_sample_t  cmp_sample,
  output mat_pkg::mat_alerts_t           alerts
);
  import mat_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [15:0]       w_data;
    logic [1:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [VAL_W-1:0]  cur_ov_clr;
    logic [VAL_W-1:0]  cur_ov_set;
    logic [VAL_W-1:0]  cur_uv_clr;
    logic [VAL_W-1:0]  cur_uv_set;
    logic [VAL_W-1:0]  ar_ov_clr;
    logic [VAL_W-1:0]  ar_ov_set;
    logic [VAL_W-1:0]  ar_uv_clr;
    logic [VAL_W-1:0]  ar_uv_set;
    logic [VAL_W-1:0]  aa_ov_clr;
    logic [VAL_W-1:0]  aa_ov_set;
    logic [VAL_W-1:0]  aa_uv_clr;
    logic [VAL_W-1:0]  aa_uv_set;
    logic [CMP_W-1:0]  cmp_ov;
    mat_alerts_t       al;
  } mat_state_t;

  mat_state_t s_q;
  mat_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] pack14(input logic [VAL_W-1:0] v);
    pack14 = {v, 2'b00};
  endfunction

  function automatic logic [VAL_W-1:0] merge14(input logic [VAL_W-1:0] old,
                                                 input logic [15:0] wd,
                                                 input logic [1:0] st);
    logic [15:0] m;
    m = pack14(old);
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    merge14 = m[15:VAL_LSB];
  endfunction

  // hysteretic over alert: set above set, clear at/below clear, else hold
  function automatic logic over_alert(input logic prev, input logic [VAL_W-1:0] code,
                                      input logic [VAL_W-1:0] set,
                                      input logic [VAL_W-1:0] clr);
    if (code > set) begin
      over_alert = 1'b1;
    end else if (code <= clr) begin
      over_alert = 1'b0;
    end else begin
      over_alert = prev;
    end
  endfunction

  // hysteretic under alert: set below set, clear at/above clear, else hold
  function automatic logic under_alert(input logic prev, input logic [VAL_W-1:0] code,
                                       input logic [VAL_W-1:0] set,
                                       input logic [VAL_W-1:0] clr);
    if (code < set) begin
      under_alert = 1'b1;
    end else if (code >= clr) begin
      under_alert = 1'b0;
    end else begin
      under_alert = prev;
    end
  endfunction

  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = {2'b00, a[ADDR_W-1:2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0]       widx;
    logic [7:0]       ridx;
    logic [15:0]      rd;
    logic             hit;
    logic [CMP_W-1:0] cmpm;
    logic [15:0]      cm;
    s_d  = s_q;
    widx = word_idx(s_q.aw_addr);
    ridx = word_idx(s_axi_araddr);
    rd   = 16'h0000;
    hit  = 1'b1;
    cmpm = s_q.cmp_ov;
    cm   = 16'h0000;

    // write address and data, taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata[15:0];
      s_d.w_strb = s_axi_wstrb[1:0];
      s_d.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (widx == IDX_CUR_OV_CLR) begin
        s_d.cur_ov_clr = merge14(s_q.cur_ov_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_CUR_OV_SET) begin
        s_d.cur_ov_set = merge14(s_q.cur_ov_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_CUR_UV_CLR) begin
        s_d.cur_uv_clr = merge14(s_q.cur_uv_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_CUR_UV_SET) begin
        s_d.cur_uv_set = merge14(s_q.cur_uv_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AR_OV_CLR) begin
        s_d.ar_ov_clr = merge14(s_q.ar_ov_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AR_OV_SET) begin
        s_d.ar_ov_set = merge14(s_q.ar_ov_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AR_UV_CLR) begin
        s_d.ar_uv_clr = merge14(s_q.ar_uv_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AR_UV_SET) begin
        s_d.ar_uv_set = merge14(s_q.ar_uv_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AA_OV_CLR) begin
        s_d.aa_ov_clr = merge14(s_q.aa_ov_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AA_OV_SET) begin
        s_d.aa_ov_set = merge14(s_q.aa_ov_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AA_UV_CLR) begin
        s_d.aa_uv_clr = merge14(s_q.aa_uv_clr, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_AA_UV_SET) begin
        s_d.aa_uv_set = merge14(s_q.aa_uv_set, s_q.w_data, s_q.w_strb);
      end else if (widx == IDX_CMP_OV) begin
        cm = {s_q.cmp_ov, 6'h00};
        if (s_q.w_strb[0]) begin
          cm[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
          cm[15:8] = s_q.w_data[15:8];
        end
        cmpm = cm[15:CMP_LSB];
        s_d.cmp_ov = cmpm;
      end else if (widx == IDX_STATUS) begin
        s_d.bresp = RESP_OKAY;
      end else begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && s_q.arready) begin
      if (ridx == IDX_CUR_OV_CLR) begin
        rd = pack14(s_q.cur_ov_clr);
      end else if (ridx == IDX_CUR_OV_SET) begin
        rd = pack14(s_q.cur_ov_set);
      end else if (ridx == IDX_CUR_UV_CLR) begin
        rd = pack14(s_q.cur_uv_clr);
      end else if (ridx == IDX_CUR_UV_SET) begin
        rd = pack14(s_q.cur_uv_set);
      end else if (ridx == IDX_AR_OV_CLR) begin
        rd = pack14(s_q.ar_ov_clr);
      end else if (ridx == IDX_AR_OV_SET) begin
        rd = pack14(s_q.ar_ov_set);
      end else if (ridx == IDX_AR_UV_CLR) begin
        rd = pack14(s_q.ar_uv_clr);
      end else if (ridx == IDX_AR_UV_SET) begin
        rd = pack14(s_q.ar_uv_set);
      end else if (ridx == IDX_AA_OV_CLR) begin
        rd = pack14(s_q.aa_ov_clr);
      end else if (ridx == IDX_AA_OV_SET) begin
        rd = pack14(s_q.aa_ov_set);
      end else if (ridx == IDX_AA_UV_CLR) begin
        rd = pack14(s_q.aa_uv_clr);
      end else if (ridx == IDX_AA_UV_SET) begin
        rd = pack14(s_q.aa_uv_set);
      end else if (ridx == IDX_CMP_OV) begin
        rd = {s_q.cmp_ov, 6'h00};
      end else if (ridx == IDX_STATUS) begin
        rd = {11'h000, s_q.al.comparator_cell_over_alert, s_q.al.aux_under_alert,
              s_q.al.aux_over_alert, s_q.al.current_low_alert,
              s_q.al.current_high_alert};
      end else begin
        hit = 1'b0;
      end
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = {16'h0000, rd};
      s_d.rresp   = hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert evaluation on each fresh measurement
    if (current_sample.valid) begin
      // codes compared as unsigned offset-binary, zero current at mid code
      s_d.al.current_high_alert = over_alert(s_q.al.current_high_alert,
        current_sample.code, s_q.cur_ov_set, s_q.cur_ov_clr);
      s_d.al.current_low_alert = under_alert(s_q.al.current_low_alert,
        current_sample.code, s_q.cur_uv_set, s_q.cur_uv_clr);
    end
    if (aux_sample.valid) begin
      if (!aux_sample.ref_abs) begin
        s_d.al.aux_over_alert = over_alert(s_q.al.aux_over_alert,
          aux_sample.code, s_q.ar_ov_set, s_q.ar_ov_clr);
        s_d.al.aux_under_alert = under_alert(s_q.al.aux_under_alert,
          aux_sample.code, s_q.ar_uv_set, s_q.ar_uv_clr);
      end else begin
        s_d.al.aux_over_alert = over_alert(s_q.al.aux_over_alert,
          aux_sample.code, s_q.aa_ov_set, s_q.aa_ov_clr);
        s_d.al.aux_under_alert = under_alert(s_q.al.aux_under_alert,
          aux_sample.code, s_q.aa_uv_set, s_q.aa_uv_clr);
      end
    end
    if (cmp_sample.valid) begin
      s_d.al.comparator_cell_over_alert = (cmp_sample.code > s_q.cmp_ov);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.awready    <= 1'b1;
      s_q.wready     <= 1'b1;
      s_q.arready    <= 1'b1;
      s_q.cur_ov_clr <= RST_HIGH;
      s_q.cur_ov_set <= RST_HIGH;
      s_q.cur_uv_clr <= RST_LOW;
      s_q.cur_uv_set <= RST_LOW;
      s_q.ar_ov_clr  <= RST_HIGH;
      s_q.ar_ov_set  <= RST_HIGH;
      s_q.ar_uv_clr  <= RST_LOW;
      s_q.ar_uv_set  <= RST_LOW;
      s_q.aa_ov_clr  <= RST_HIGH;
      s_q.aa_ov_set  <= RST_HIGH;
      s_q.aa_uv_clr  <= RST_LOW;
      s_q.aa_uv_set  <= RST_LOW;
      s_q.cmp_ov     <= RST_CMP;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign alerts        = s_q.al;
endmodule
`default_nettype wire

// File: mat_alert_thresholds_props.sv
// checker: port-level properties of the alert threshold block
`timescale 1ns/10ps
`default_nettype none
module mat_alert_thresholds_props
  import mat_pkg::*;
(
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [DATA_W-1:0]        s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire mat_pkg::mat_sample_t     current_sample,
  input wire mat_pkg::mat_aux_sample_t aux_sample,
  input wire mat_pkg::mat_cmp_sample_t cmp_sample,
  input wire mat_pkg::mat_alerts_t     alerts
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_alert_hold: assert property (
    !(current_sample.valid || aux_sample.valid || cmp_sample.valid) |=> $stable(alerts))
    else $error("alert moved without sample");
  a_high_floor: assert property (
    current_sample.valid && current_sample.code == 14'h0000 |=> !alerts.current_high_alert)
    else $error("current high alert at floor");
  a_low_top: assert property (
    current_sample.valid && current_sample.code == 14'h3FFF |=> !alerts.current_low_alert)
    else $error("current low alert at top");
  a_aux_over_floor: assert property (
    aux_sample.valid && aux_sample.code == 14'h0000 |=> !alerts.aux_over_alert)
    else $error("aux over alert at floor");
  a_aux_under_top: assert property (
    aux_sample.valid && aux_sample.code == 14'h3FFF |=> !alerts.aux_under_alert)
    else $error("aux under alert at top");
  a_cmp_floor: assert property (
    cmp_sample.valid && cmp_sample.code == 10'h000 |=> !alerts.comparator_cell_over_alert)
    else $error("comparator alert at floor");
  ////////////////////////////////////////////////////////////////////////////////
  c_high_rise: cover property ($rose(alerts.current_high_alert));
  c_under_rise: cover property ($rose(alerts.aux_under_alert));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// File: mat_alert_thresholds_tb.sv
// testbench: registers, bus answers and alert hysteresis of the threshold block
`timescale 1ns/10ps
`default_nettype none
module mat_alert_thresholds_tb;
  import mat_pkg::*;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  mat_sample_t       cur_s;
  mat_aux_sample_t   aux_s;
  mat_cmp_sample_t   cmp_s;
  mat_alerts_t       alerts, exp_al;
  logic [15:0]       img [NUM_THR];
  integer            seed;
  int                err_total = 0;
  int                tests_run = 0;
  int                cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  mat_alert_thresholds dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .current_sample(cur_s), .aux_sample(aux_s), .cmp_sample(cmp_s), .alerts(alerts)
  );
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tally(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, exp);
    tally(got === exp, $sformatf("word %h expected %h", got, exp));
  endtask
  task automatic chk_resp(input logic [1:0] got, exp);
    tally(got === exp, $sformatf("response %h expected %h", got, exp));
  endtask
  task automatic chk_alerts(input mat_alerts_t got, exp);
    tally(got === exp, $sformatf("alerts %b expected %b", got, exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic hyst(input logic prev, over, input logic [13:0] c, s, k);
    if (over) return (c > s) ? 1'b1 : (c <= k) ? 1'b0 : prev;
    return (c < s) ? 1'b1 : (c >= k) ? 1'b0 : prev;
  endfunction
  task automatic check_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < NUM_THR; i++) begin
      bus_read(8'(4 * (IDX_CUR_OV_CLR + i)), d, r);
      chk_resp(r, RESP_OKAY);
      chk_word(d, {16'h0000, img[i]});
    end
  endtask
  task automatic program_all();
    logic [15:0] a, b, lo, hi, w0, w1;
    logic [1:0]  r;
    for (int i = 0; i <= NUM_THR; i += 2) begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      w0 = (i == 12) ? a : (i % 4 == 0) ? lo : hi;
      w1 = (i % 4 == 0) ? hi : lo;
      img[i] = w0 & ((i == 12) ? 16'hFFC0 : 16'hFFFC);
      bus_write(8'(4 * (IDX_CUR_OV_CLR + i)), {16'($random(seed)), w0}, r);
      chk_resp(r, RESP_OKAY);
      if (i < 12) begin
        img[i + 1] = w1 & 16'hFFFC;
        bus_write(8'(4 * (IDX_CUR_OV_CLR + i + 1)), {16'($random(seed)), w1}, r);
        chk_resp(r, RESP_OKAY);
      end
    end
  endtask
  task automatic push(input int j);
    logic [13:0] c;
    logic [2:0]  v;
    int          o;
    c = (j % 8 == 0) ? 14'h0000 : (j % 8 == 1) ? 14'h3FFF : (j % 8 == 2) ? img[1][15:2]
        : (j % 8 == 3) ? img[3][15:2] : 14'($random(seed));
    v = (j % 8 < 2) ? 3'h7 : 3'($random(seed));
    o = (j % 3 == 0) ? 4 : 0;
    @(posedge aclk);
    cur_s <= '{v[0], c};
    aux_s <= '{v[1], o == 4, ~c};
    cmp_s <= '{v[2], c[13:4]};
    if (v[0]) begin
      exp_al.current_high_alert = hyst(exp_al.current_high_alert, 1'b1, c,
                                       img[1][15:2], img[0][15:2]);
      exp_al.current_low_alert = hyst(exp_al.current_low_alert, 1'b0, c,
                                      img[3][15:2], img[2][15:2]);
    end
    if (v[1]) begin
      exp_al.aux_over_alert = hyst(exp_al.aux_over_alert, 1'b1, ~c,
                                   img[5 + o][15:2], img[4 + o][15:2]);
      exp_al.aux_under_alert = hyst(exp_al.aux_under_alert, 1'b0, ~c,
                                    img[7 + o][15:2], img[6 + o][15:2]);
    end
    if (v[2]) exp_al.comparator_cell_over_alert = c[13:4] > img[12][15:6];
    @(posedge aclk);
    cur_s.valid <= 1'b0;
    aux_s.valid <= 1'b0;
    cmp_s.valid <= 1'b0;
    @(negedge aclk);
    chk_alerts(alerts, exp_al);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    seed = 32'hf677e1f1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    cur_s = '0;
    aux_s = '0;
    cmp_s = '0;
    exp_al = '0;
    for (int i = 0; i < NUM_THR; i++) begin
      img[i] = (i == 12) ? {RST_CMP, 6'h00} : {(i % 4 < 2) ? RST_HIGH : RST_LOW, 2'h0};
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus_read(8'hEC, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_word(d, 32'h0000_0000);
    bus_write(8'hEC, 32'h0000_FFFF, r);
    chk_resp(r, RESP_SLVERR);
    bus_write(8'(4 * IDX_STATUS), 32'h0000_001F, r);
    chk_resp(r, RESP_OKAY);
    // low byte strobe only: upper byte keeps its reset value
    wstrb <= 4'h1;
    bus_write(8'(4 * IDX_CUR_UV_CLR), 32'hFFFF_FFFF, r);
    wstrb <= 4'hF;
    chk_resp(r, RESP_OKAY);
    img[2] = 16'h00FC;
    check_regs();
    for (int j = 0; j < 48; j++) push(j);
    repeat (8) begin
      program_all();
      check_regs();
      for (int j = 0; j < 64; j++) push(j);
      bus_read(8'(4 * IDX_STATUS), d, r);
      chk_resp(r, RESP_OKAY);
      chk_word(d, {27'h0, exp_al.comparator_cell_over_alert, exp_al.aux_under_alert,
                   exp_al.aux_over_alert, exp_al.current_low_alert,
                   exp_al.current_high_alert});
    end
    complete_run();
  end
endmodule
bind mat_alert_thresholds mat_alert_thresholds_props props_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .current_sample(current_sample), .aux_sample(aux_sample),
  .cmp_sample(cmp_sample), .alerts(alerts)
);
`default_nettype wire

// File: mat_pkg.sv
// package: register map, field layout and carriers for the alert threshold block
package mat_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 14;
  localparam int CMP_W = 10;
  localparam int VAL_LSB = 2;
  localparam int CMP_LSB = 6;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CUR_OV_CLR = 8'h2C;
  localparam logic [7:0] IDX_CUR_OV_SET = 8'h2D;
  localparam logic [7:0] IDX_CUR_UV_CLR = 8'h2E;
  localparam logic [7:0] IDX_CUR_UV_SET = 8'h2F;
  localparam logic [7:0] IDX_AR_OV_CLR = 8'h30;
  localparam logic [7:0] IDX_AR_OV_SET = 8'h31;
  localparam logic [7:0] IDX_AR_UV_CLR = 8'h32;
  localparam logic [7:0] IDX_AR_UV_SET = 8'h33;
  localparam logic [7:0] IDX_AA_OV_CLR = 8'h34;
  localparam logic [7:0] IDX_AA_OV_SET = 8'h35;
  localparam logic [7:0] IDX_AA_UV_CLR = 8'h36;
  localparam logic [7:0] IDX_AA_UV_SET = 8'h37;
  localparam logic [7:0] IDX_CMP_OV = 8'h38;
  localparam logic [7:0] IDX_STATUS = 8'h3A;
  localparam int NUM_THR = 13;
  // thresholds reset values, 14-bit and 10-bit fields
  localparam logic [13:0] RST_HIGH = 14'h3FFF;
  localparam logic [13:0] RST_LOW = 14'h0000;
  localparam logic [9:0] RST_CMP = 10'h3FF;
  localparam logic [13:0] ZERO_CURRENT = 14'h2000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int ST_CUR_HI = 0;
  localparam int ST_CUR_LO = 1;
  localparam int ST_AUX_OV = 2;
  localparam int ST_AUX_UV = 3;
  localparam int ST_CMP_OV = 4;

  typedef struct packed {
    logic              valid;
    logic [VAL_W-1:0]  code;
  } mat_sample_t;

  typedef struct packed {
    logic              valid;
    logic              ref_abs;
    logic [VAL_W-1:0]  code;
  } mat_aux_sample_t;

  typedef struct packed {
    logic              valid;
    logic [CMP_W-1:0]  code;
  } mat_cmp_sample_t;

  typedef struct packed {
    logic current_high_alert;
    logic current_low_alert;
    logic aux_over_alert;
    logic aux_under_alert;
    logic comparator_cell_over_alert;
  } mat_alerts_t;
endpackage
